/* rtl/line_energy_metering.sv */
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
module line_energy_metering import line_energy_pkg::*; #(
  parameter int POWER_W = 28
) (
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      resetn,
  // APB slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // Line and power inputs
  input  wire logic                      zero_cross_in,
  input  wire logic signed [POWER_W-1:0] power_sample,
  // Outputs
  output logic                           energy_pulse_output,
  output logic                           irq_n_out,
  output logic                           irq_n_oe
);
  if (POWER_W < 8 || POWER_W > 30) begin : g_bad_width
    $error("POWER_W must lie between 8 and 30");
  end

  // Registers.
  logic                       line_en, next_line_en;
  logic signed [GAIN_W-1:0]   active_gain_trim, next_gain;
  logic signed [OFFSET_W-1:0] active_power_offset, next_offset;
  logic [HALF_W-1:0]          half_cycle_count, next_half_cycle_count;
  logic [PULSE_W-1:0]         pulse_numerator, next_pnum;
  logic [PULSE_W-1:0]         pulse_denominator, next_pden;
  logic [DIV_W-1:0]           energy_divider, next_div;
  logic [IRQ_W-1:0]           irq_status, next_status;
  logic [IRQ_W-1:0]           irq_mask, next_mask;
  logic [31:0]                next_prdata;
  logic                       hit;
  logic                       wr;
  // Measurement and energy state.
  logic [PRESC_W-1:0]         presc;
  logic                       zc_s1, zc_s2, zc_s3, zc_level;
  logic [PERIOD_W-1:0]        period_count, next_period_count;
  logic [PERIOD_W-1:0]        line_period, next_line_period;
  logic [HALF_W-1:0]          half_seen, next_half_seen;
  logic signed [FINE_W-1:0]   fine_accum, next_fine;
  logic signed [FINE_W-1:0]   fine_delta;
  logic signed [POWER_W+GAIN_W+1:0] gained_full;
  logic [ENERGY_W-1:0]        active_energy_accum, next_accum;
  logic [ENERGY_W-1:0]        window_energy, next_window;
  logic [ENERGY_W-1:0]        window_sum;
  logic [ENERGY_W-1:0]        line_active_energy, next_line_energy;
  logic [DIV_W-1:0]           div_den;
  logic                       energy_update, tick8, half_edge, rise_edge, window_end;
  logic                       step_up, step_down, div_up, div_down;

  assign energy_update = presc[1:0] == UPDATE_PHASE;
  assign tick8         = presc == TICK_PHASE;
  assign half_edge     = (zc_s2 == zc_s3) && (zc_s3 != zc_level);
  assign rise_edge     = half_edge && zc_s3;
  assign window_end    = line_en && half_edge && (half_cycle_count != '0) &&
                         ({1'b0, half_seen} + 17'h00001 >= {1'b0, half_cycle_count});

  // Gained power plus offset, in units of 2^-33 of the energy LSB.
  assign gained_full = power_sample * (GAIN_UNITY + (GAIN_W+2)'(active_gain_trim));
  assign fine_delta  = FINE_W'(gained_full >>> GAIN_FRAC) + FINE_W'(active_power_offset);
  assign next_fine   = energy_update ? fine_accum + fine_delta : fine_accum;
  assign step_up     = energy_update && !fine_delta[FINE_W-1] &&
                       (next_fine[FINE_W-1:FINE_SHIFT] != fine_accum[FINE_W-1:FINE_SHIFT]);
  assign step_down   = energy_update && fine_delta[FINE_W-1] &&
                       (next_fine[FINE_W-1:FINE_SHIFT] != fine_accum[FINE_W-1:FINE_SHIFT]);

  // A zero divider means divide by one.
  assign div_den = (energy_divider == '0) ? '0 : energy_divider - DIV_W'(1);

  ratio_scaler #(.W(DIV_W)) u_divider (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .step_up   (step_up),
    .step_down (step_down),
    .num       ('0),
    .den       (div_den),
    .pulse_up  (div_up),
    .pulse_down(div_down)
  );

  // The pulse path takes the undivided steps.
  ratio_scaler #(.W(PULSE_W)) u_pulse (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .step_up   (step_up),
    .step_down (step_down),
    .num       (pulse_numerator),
    .den       (pulse_denominator),
    .pulse_up  (energy_pulse_output),
    .pulse_down()
  );

  assign window_sum = div_up ? window_energy + ENERGY_W'(1) :
                      div_down ? window_energy - ENERGY_W'(1) : window_energy;

  always_comb begin
    next_accum        = div_up ? active_energy_accum + ENERGY_W'(1) :
                        div_down ? active_energy_accum - ENERGY_W'(1) : active_energy_accum;
    next_window       = line_en ? window_sum : '0;
    next_half_seen    = line_en ? half_seen : '0;
    next_line_energy  = line_active_energy;
    next_period_count = (tick8 && period_count != '1) ? period_count + PERIOD_W'(1) : period_count;
    next_line_period  = line_period;
    if (rise_edge) begin
      next_line_period  = period_count;
      next_period_count = '0;
    end
    if (line_en && half_edge) begin
      next_half_seen = half_seen + HALF_W'(1);
    end
    if (window_end) begin
      next_line_energy = window_sum;
      next_window      = '0;
      next_half_seen   = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      presc               <= '0;
      zc_s1               <= 1'b0;
      zc_s2               <= 1'b0;
      zc_s3               <= 1'b0;
      zc_level            <= 1'b0;
      fine_accum          <= '0;
      active_energy_accum <= '0;
      window_energy       <= '0;
      line_active_energy  <= '0;
      half_seen           <= '0;
      period_count        <= '0;
      line_period         <= '0;
    end else begin
      presc               <= presc + PRESC_W'(1);
      zc_s1               <= zero_cross_in;
      zc_s2               <= zc_s1;
      zc_s3               <= zc_s2;
      zc_level            <= half_edge ? zc_s3 : zc_level;
      fine_accum          <= next_fine;
      active_energy_accum <= next_accum;
      window_energy       <= next_window;
      line_active_energy  <= next_line_energy;
      half_seen           <= next_half_seen;
      period_count        <= next_period_count;
      line_period         <= next_line_period;
    end
  end

  // APB register file; read data is captured in the setup cycle.
  assign wr      = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign hit     = paddr[1:0] == 2'b00 && paddr <= MASK_OFS;

  always_comb begin
    next_line_en          = line_en;
    next_gain             = active_gain_trim;
    next_offset           = active_power_offset;
    next_half_cycle_count = half_cycle_count;
    next_pnum             = pulse_numerator;
    next_pden             = pulse_denominator;
    next_div              = energy_divider;
    next_mask             = irq_mask;
    next_status           = irq_status;
    if (wr) begin
      unique case (paddr)
        CTRL_OFS:   next_line_en          = pwdata[CTRL_LINE_EN_BIT];
        GAIN_OFS:   next_gain             = pwdata[GAIN_W-1:0];
        OFFSET_OFS: next_offset           = pwdata[OFFSET_W-1:0];
        HALF_OFS:   next_half_cycle_count = pwdata[HALF_W-1:0];
        PNUM_OFS:   next_pnum             = pwdata[PULSE_W-1:0];
        PDEN_OFS:   next_pden             = pwdata[PULSE_W-1:0];
        DIV_OFS:    next_div              = pwdata[DIV_W-1:0];
        MASK_OFS:   next_mask             = pwdata[IRQ_W-1:0];
        STATUS_OFS: next_status           = irq_status & ~pwdata[IRQ_W-1:0];
        default:    next_mask             = irq_mask;
      endcase
    end
    next_status[IRQ_WINDOW_BIT] = next_status[IRQ_WINDOW_BIT] | window_end;
    next_status[IRQ_ZX_BIT]     = next_status[IRQ_ZX_BIT] | half_edge;
    next_prdata = '0;
    unique case (paddr)
      CTRL_OFS:   next_prdata = 32'(line_en);
      GAIN_OFS:   next_prdata = 32'(unsigned'(active_gain_trim));
      OFFSET_OFS: next_prdata = 32'(unsigned'(active_power_offset));
      HALF_OFS:   next_prdata = 32'(half_cycle_count);
      PNUM_OFS:   next_prdata = 32'(pulse_numerator);
      PDEN_OFS:   next_prdata = 32'(pulse_denominator);
      DIV_OFS:    next_prdata = 32'(energy_divider);
      ACCUM_OFS:  next_prdata = 32'(active_energy_accum);
      LINE_OFS:   next_prdata = 32'(line_active_energy);
      PERIOD_OFS: next_prdata = 32'(line_period);
      STATUS_OFS: next_prdata = 32'(irq_status);
      MASK_OFS:   next_prdata = 32'(irq_mask);
      default:    next_prdata = '0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      line_en             <= 1'b0;
      active_gain_trim    <= '0;
      active_power_offset <= '0;
      half_cycle_count    <= '0;
      pulse_numerator     <= PNUM_RESET;
      pulse_denominator   <= PDEN_RESET;
      energy_divider      <= '0;
      irq_mask            <= '0;
      irq_status          <= '0;
      prdata              <= '0;
    end else begin
      line_en             <= next_line_en;
      active_gain_trim    <= next_gain;
      active_power_offset <= next_offset;
      half_cycle_count    <= next_half_cycle_count;
      pulse_numerator     <= next_pnum;
      pulse_denominator   <= next_pden;
      energy_divider      <= next_div;
      irq_mask            <= next_mask;
      irq_status          <= next_status;
      prdata              <= (psel && !penable) ? next_prdata : prdata;
    end
  end

  // Open-drain interrupt: driven low while an unmasked status bit is set.
  assign irq_n_out = 1'b0;
  assign irq_n_oe  = |(irq_status & irq_mask);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  property p_window_irq;
    window_end && irq_mask[IRQ_WINDOW_BIT] |=> irq_n_oe && !irq_n_out;
  endproperty
  a_window_irq: assert property (p_window_irq) else $error("window end did not raise interrupt");
  property p_update_rate;
    energy_update |=> !energy_update [*3] ##1 energy_update;
  endproperty
  a_update_rate: assert property (p_update_rate) else $error("energy update not every four clocks");
  property p_hold_between;
    !energy_update |=> fine_accum == $past(fine_accum);
  endproperty
  a_hold_between: assert property (p_hold_between) else $error("energy moved between updates");
  property p_unity_gain;
    energy_update && active_gain_trim == '0 && active_power_offset == '0 |-> fine_delta == FINE_W'(power_sample);
  endproperty
  a_unity_gain: assert property (p_unity_gain) else $error("zero gain changed power");
  property p_offset_only;
    energy_update && power_sample == '0 |=> fine_accum == $past(fine_accum) + FINE_W'($past(active_power_offset));
  endproperty
  a_offset_only: assert property (p_offset_only) else $error("offset not added once per update");
  property p_period_latch;
    rise_edge |=> line_period == $past(period_count) && period_count == '0;
  endproperty
  a_period_latch: assert property (p_period_latch) else $error("line period not latched");
  property p_window_len;
    window_end |-> half_seen + HALF_W'(1) >= half_cycle_count;
  endproperty
  a_window_len: assert property (p_window_len) else $error("window ended early");
  property p_window_bound;
    line_en && half_cycle_count != '0 && $stable(half_cycle_count) |-> half_seen < half_cycle_count;
  endproperty
  a_window_bound: assert property (p_window_bound) else $error("half cycle count overran");
  property p_window_latch;
    window_end |=> line_active_energy == $past(window_sum) && window_energy == '0;
  endproperty
  a_window_latch: assert property (p_window_latch) else $error("window energy not latched and cleared");
  property p_pulse_cause;
    energy_pulse_output |-> $past(step_up);
  endproperty
  a_pulse_cause: assert property (p_pulse_cause) else $error("pulse without undivided energy step");

  c_window:   cover property (window_end);
  c_pulse:    cover property (energy_pulse_output);
  c_negative: cover property (step_down);
  c_slverr:   cover property (pslverr);
endmodule // line_energy_metering

/* rtl/ratio_scaler.sv */
`timescale 1ns/1ps
module ratio_scaler #(
  parameter int W = 12
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         resetn,
  // Signed input steps
  input  wire logic         step_up,
  input  wire logic         step_down,
  // Ratio (num+1)/(den+1) while num <= den
  input  wire logic [W-1:0] num,
  input  wire logic [W-1:0] den,
  // Scaled output steps
  output logic              pulse_up,
  output logic              pulse_down
);
  logic signed [W+2:0] acc;
  logic signed [W+2:0] next_acc;
  logic                next_up;
  logic                next_down;
  logic signed [W+2:0] inc;
  logic signed [W+2:0] mod;
  logic signed [W+2:0] base;

  if (W < 1) begin : g_bad_width
    $error("W must be at least 1");
  end

  // Each up step adds num+1 and each down step subtracts it; each den+1 gathered gives one output step while num <= den.
  // A remainder left above a newly lowered denominator restarts at zero, so no stale state keeps stepping.
  always_comb begin
    inc       = $signed({3'b000, num}) + (W+3)'(1);
    mod       = $signed({3'b000, den}) + (W+3)'(1);
    base      = (acc >= mod) ? '0 : acc;
    next_acc  = base;
    next_up   = 1'b0;
    next_down = 1'b0;
    if (step_up) begin
      next_acc = base + inc;
    end else if (step_down) begin
      next_acc = base - inc;
    end
    if (next_acc >= mod) begin
      next_acc = next_acc - mod;
      next_up  = 1'b1;
    end else if (next_acc < 0) begin
      next_acc  = next_acc + mod;
      next_down = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      acc        <= '0;
      pulse_up   <= 1'b0;
      pulse_down <= 1'b0;
    end else begin
      acc        <= next_acc;
      pulse_up   <= next_up;
      pulse_down <= next_down;
    end
  end

  property p_ratio_range;
    @(posedge core_clk) disable iff (!resetn)
      (num <= den) |=> (acc >= 0 && acc <= $signed({3'b000, $past(den)}));
  endproperty
  a_ratio_range: assert property (p_ratio_range) else $error("ratio remainder out of range");
endmodule // ratio_scaler

/* shared/line_energy_pkg.sv */
package line_energy_pkg;
  // Register byte offsets on the APB bus.
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] GAIN_OFS   = 8'h04;
  localparam logic [7:0] OFFSET_OFS = 8'h08;
  localparam logic [7:0] HALF_OFS   = 8'h0c;
  localparam logic [7:0] PNUM_OFS   = 8'h10;
  localparam logic [7:0] PDEN_OFS   = 8'h14;
  localparam logic [7:0] DIV_OFS    = 8'h18;
  localparam logic [7:0] ACCUM_OFS  = 8'h1c;
  localparam logic [7:0] LINE_OFS   = 8'h20;
  localparam logic [7:0] PERIOD_OFS = 8'h24;
  localparam logic [7:0] STATUS_OFS = 8'h28;
  localparam logic [7:0] MASK_OFS   = 8'h2c;
  // Field positions.
  localparam int CTRL_LINE_EN_BIT = 0;
  localparam int IRQ_WINDOW_BIT   = 0;
  localparam int IRQ_ZX_BIT       = 1;
  localparam int IRQ_W            = 2;
  // Field widths.
  localparam int GAIN_W   = 12;
  localparam int OFFSET_W = 16;
  localparam int HALF_W   = 16;
  localparam int PULSE_W  = 12;
  localparam int DIV_W    = 8;
  localparam int ENERGY_W = 24;
  localparam int PERIOD_W = 16;
  localparam int FINE_W   = 64;
  // Gain is a fraction of 2^12; fine energy carries 33 bits below the energy LSB.
  localparam int GAIN_FRAC  = 12;
  localparam int FINE_SHIFT = 33;
  localparam logic signed [GAIN_W+1:0] GAIN_UNITY = 14'sh1000;
  // Timing: update every 4 clocks, period tick every 8 clocks.
  localparam int PRESC_W = 3;
  localparam logic [1:0] UPDATE_PHASE = 2'h3;
  localparam logic [2:0] TICK_PHASE   = 3'h7;
  // Reset values.
  localparam logic [PULSE_W-1:0] PNUM_RESET = 12'h03f;
  localparam logic [PULSE_W-1:0] PDEN_RESET = 12'h03f;
endpackage

/* verif/host_mcu_model.sv */
`timescale 1ns/1ps
module host_mcu_model import line_energy_pkg::*; (
  // Clock
  input  wire logic        core_clk,
  // APB master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  // Address and data are inverted on release so a stale value is never mistaken for a live one.
  task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                          output logic [31:0] rd, output logic err);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) begin
      @(posedge core_clk);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~wd;
  endtask

  task automatic gain_cal_setup(input logic [11:0] den, input logic [15:0] half);
    logic [31:0] r;
    logic        e;
    apb_xfer(1'b1, PDEN_OFS, {20'h0, den}, r, e);
    apb_xfer(1'b1, PNUM_OFS, 32'h0, r, e);
    apb_xfer(1'b1, CTRL_OFS, 32'h1, r, e);
    apb_xfer(1'b1, MASK_OFS, 32'h1, r, e);
    apb_xfer(1'b1, HALF_OFS, {16'h0, half}, r, e);
    apb_xfer(1'b1, STATUS_OFS, 32'h3, r, e);
  endtask
endmodule // host_mcu_model

/* verif/testbench.sv */
`timescale 1ns/1ps
module testbench import line_energy_pkg::*;;
  localparam int PW       = 28;
  localparam int HALF_LEN = 256;
  logic                 core_clk      = 1'b0;
  logic                 resetn        = 1'b0;
  logic                 zero_cross_in = 1'b0;
  logic signed [PW-1:0] power_sample  = '0;
  logic                 zc_run        = 1'b0;
  logic                 psel, penable, pwrite, pready, pslverr;
  logic [7:0]           paddr;
  logic [31:0]          pwdata, prdata;
  logic                 energy_pulse_output, irq_n_out, irq_n_oe, irq_line;
  int                   cyc = 0, zc_cnt = 0, pulse_count = 0, bad_count = 0, checked = 0;

  always #10 core_clk = ~core_clk;
  // The interrupt pin is open drain with a pull-up.
  assign irq_line = irq_n_oe ? irq_n_out : 1'b1;

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (energy_pulse_output === 1'b1) pulse_count <= pulse_count + 1;
    if (zc_run) begin
      zc_cnt <= (zc_cnt == HALF_LEN - 1) ? 0 : zc_cnt + 1;
      if (zc_cnt == HALF_LEN - 1) zero_cross_in <= ~zero_cross_in;
    end
  end

  line_energy_metering #(.POWER_W(PW)) DUT (
    .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .zero_cross_in(zero_cross_in), .power_sample(power_sample),
    .energy_pulse_output(energy_pulse_output), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));

  host_mcu_model host (
    .core_clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_range(input string name, input int lo, input int hi, input logic [31:0] got);
    checked++;
    if ((^got === 1'bx) || got < lo || got > hi) begin
      bad_count++;
      $display("BAD %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    host.apb_xfer(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic e;
    host.apb_xfer(1'b0, a, 32'h0, d, e);
  endtask

  // One edge is let pass first so a status clear that just landed is seen.
  task automatic wait_irq(output int t);
    int n;
    n = 0;
    @(posedge core_clk);
    while (irq_line !== 1'b0 && n < 5000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 5000) check_val("irq wait", 32'h0, 32'h1);
    t = cyc;
  endtask

  task automatic test_reset;
    logic [31:0] v;
    rd(PNUM_OFS, v);
    check_val("pnum reset", 32'h3f, v);
    rd(PDEN_OFS, v);
    check_val("pden reset", 32'h3f, v);
    rd(STATUS_OFS, v);
    check_val("status reset", 32'h0, v);
    rd(ACCUM_OFS, v);
    check_val("accum reset", 32'h0, v);
    $display("reset test done");
  endtask

  task automatic test_offset;
    logic [31:0] v;
    wr(OFFSET_OFS, 32'hffff);
    repeat (12) @(posedge core_clk);
    rd(ACCUM_OFS, v);
    check_val("accum negative offset", 32'hffffff, v);
    wr(OFFSET_OFS, 32'h1);
    repeat (100) @(posedge core_clk);
    rd(ACCUM_OFS, v);
    check_val("accum positive offset", 32'h0, v);
    wr(OFFSET_OFS, 32'h0);
    $display("offset test done");
  endtask

  task automatic test_regs;
    logic [31:0] v, a0;
    logic        e;
    wr(GAIN_OFS, 32'hffff_f123);
    rd(GAIN_OFS, v);
    check_val("gain readback", 32'h123, v);
    wr(HALF_OFS, 32'h1_ffff);
    rd(HALF_OFS, v);
    check_val("half count max", 32'hffff, v);
    rd(ACCUM_OFS, a0);
    wr(ACCUM_OFS, 32'h55);
    rd(ACCUM_OFS, v);
    check_val("accum read only", a0, v);
    host.apb_xfer(1'b0, 8'h30, 32'h0, v, e);
    check_val("unmapped err", 32'h1, e);
    check_val("unmapped data", 32'h0, v);
    host.apb_xfer(1'b1, 8'h05, 32'h1, v, e);
    check_val("unaligned err", 32'h1, e);
    wr(GAIN_OFS, 32'h0);
    $display("register test done");
  endtask

  task automatic test_irq;
    logic [31:0] v;
    int          t;
    wr(MASK_OFS, 32'h2);
    zc_run <= 1'b1;
    wait_irq(t);
    rd(STATUS_OFS, v);
    check_val("zero cross status", 32'h1, v[IRQ_ZX_BIT]);
    wr(MASK_OFS, 32'h0);
    @(posedge core_clk);
    check_val("irq masked", 32'h0, irq_n_oe);
    $display("interrupt test done");
  endtask

  task automatic test_window;
    logic [31:0] v;
    int          t0, t1, t2;
    power_sample <= 28'sd67108864;
    host.gain_cal_setup(12'h001, 16'h0004);
    wait_irq(t0);
    wr(STATUS_OFS, 32'h1);
    wait_irq(t1);
    check_val("irq pin", 32'h0, irq_line);
    rd(LINE_OFS, v);
    check_val("line energy", 32'h2, v);
    rd(LINE_OFS, v);
    check_val("line energy reread", 32'h2, v);
    wr(STATUS_OFS, 32'h1);
    wait_irq(t2);
    rd(LINE_OFS, v);
    check_val("line energy restart", 32'h2, v);
    check_val("window cycles", 32'd1024, t2 - t1);
    rd(PERIOD_OFS, v);
    check_range("line period", 63, 64, v);
    $display("window test done");
  endtask

  task automatic test_gain;
    logic [31:0] v;
    int          t;
    wr(GAIN_OFS, 32'h800);
    wr(STATUS_OFS, 32'h1);
    wait_irq(t);
    wr(STATUS_OFS, 32'h1);
    wait_irq(t);
    rd(LINE_OFS, v);
    check_val("line energy half gain", 32'h1, v);
    wr(GAIN_OFS, 32'h0);
    wr(OFFSET_OFS, 32'h0);
    wr(CTRL_OFS, 32'h0);
    $display("gain test done");
  endtask

  task automatic pulse_case(input logic [31:0] div, input logic [31:0] den, input int plo, input int phi,
                            input int alo, input int ahi);
    logic [31:0] a0, a1;
    int          p0;
    wr(DIV_OFS, div);
    wr(PDEN_OFS, den);
    rd(ACCUM_OFS, a0);
    p0 = pulse_count;
    repeat (4096) @(posedge core_clk);
    rd(ACCUM_OFS, a1);
    check_range("pulses", plo, phi, pulse_count - p0);
    check_range("accum steps", alo, ahi, (a1 - a0) & 32'hffffff);
  endtask

  initial begin
    repeat (5) @(posedge core_clk);
    check_val("irq in reset", 32'h0, irq_n_oe);
    resetn <= 1'b1;
    test_reset();
    test_offset();
    test_regs();
    test_irq();
    test_window();
    test_gain();
    pulse_case(32'h2, 32'h0, 7, 9, 3, 5);
    pulse_case(32'h1, 32'h1, 3, 5, 7, 9);
    $display("pulse test done");
    complete_run();
  end

  initial begin
    #800_000;
    check_val("watchdog", 32'h0, 32'h1);
    complete_run();
  end
endmodule // testbench
